// ==== rtl/cmpdc_pkg.sv ====
// cmpdc_pkg: constants and types for the four-comparator digital control
// assumes: 8-bit register port, 25 MHz mclk, synchronous active-high reset
package cmpdc_pkg;
    localparam int unsigned NUM_CMP = 4;
    // register offsets, comparator n uses base + 2*n
    localparam logic [3:0] OFF_CTRL_A_BASE = 4'h0;
    localparam logic [3:0] OFF_CTRL_B_BASE = 4'h1;
    localparam logic [3:0] OFF_MIRROR = 4'h8;
    localparam logic [3:0] OFF_IRQ_FLAGS = 4'h9;
    // control a field positions
    localparam int unsigned A_ON = 7;
    localparam int unsigned A_OUT = 6;
    localparam int unsigned A_OE = 5;
    localparam int unsigned A_POL = 4;
    localparam int unsigned A_ZLF = 3;
    localparam int unsigned A_SP = 2;
    localparam int unsigned A_HYS = 1;
    localparam int unsigned A_SYNC = 0;
    // control b field positions
    localparam int unsigned B_RISE = 7;
    localparam int unsigned B_FALL = 6;
    localparam int unsigned B_PSEL_LO = 3;
    localparam int unsigned B_NSEL_LO = 0;
    // reset values: speed_select comes up set
    localparam logic [7:0] CTRL_A_RST = 8'h04;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    // plus and minus selector codes
    localparam logic [2:0] PSEL_PIN0 = 3'h0;
    localparam logic [2:0] PSEL_PIN1 = 3'h1;
    localparam logic [2:0] PSEL_DAC = 3'h5;
    localparam logic [2:0] PSEL_FVR = 3'h6;
    localparam logic [2:0] SEL_GND = 3'h7;
    localparam logic [2:0] NSEL_PIN4 = 3'h4;
    // anti-oscillation hold
    localparam int unsigned ZLF_HOLD_NS = 20;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned ZLF_HOLD_CYC_RAW = ZLF_HOLD_NS / CLK_PERIOD_NS;
    localparam logic [1:0] ZLF_HOLD_CYC =
        (ZLF_HOLD_CYC_RAW < 1) ? 2'h1 : ZLF_HOLD_CYC_RAW[1:0];

    // analog steering per comparator
    typedef struct packed {
        logic enable;      // powered, inputs connected
        logic [4:0] plus_sel;   // one-hot: pin0, pin1, dac, fvr2, gnd
        logic [5:0] minus_sel;  // one-hot: pins 0..4, gnd
        logic minus_opamp;      // opamp output feeds inverting input
        logic high_speed;
        logic hysteresis;
    } cmpdc_ana_t;

    typedef struct packed {
        logic [NUM_CMP-1:0][7:0] ctrl_a;
        logic [NUM_CMP-1:0][7:0] ctrl_b;
        logic [NUM_CMP-1:0] raw_q;      // first sync stage
        logic [NUM_CMP-1:0] raw_s;      // synchronised compare
        logic [NUM_CMP-1:0] result;     // latched, polarity and filter applied
        logic [NUM_CMP-1:0][1:0] hold;  // filter hold counters
        logic [NUM_CMP-1:0] prev;
        logic [NUM_CMP-1:0] ext;        // output to timer and pin
        logic [NUM_CMP-1:0] irq;
        logic tclk_prev;
        logic [7:0] rdata;
    } cmpdc_state_t;
endpackage

// ==== rtl/cmpdc_top.sv ====
// cmpdc_top: digital control of four analog comparators
// assumes: analog compare results arrive as levels, timer clock as a
// level sampled on mclk, register port with read data one cycle later
`timescale 1ns/10ps
`default_nettype none
module cmpdc_top
    import cmpdc_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst, // sync reset, active high
    input wire logic ce, // clock enable
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd_en
    input wire logic [NUM_CMP-1:0] ana_gt, // plus above minus, per comparator
    input wire logic [NUM_CMP-1:0][4:0] minus_opamp_en, // opamp on minus pin
    input wire logic tmr_clk, // timer clock source level
    input wire logic [NUM_CMP-1:0] pin_dir_in, // direction bit, 1 = input
    input wire logic [NUM_CMP-1:0] pin_analog, // pin set analog
    input wire logic [NUM_CMP-1:0] pin_port_in, // digital pin level
    output logic [NUM_CMP-1:0] pin_port_rd, // port read value
    output logic [NUM_CMP-1:0] pin_out, // output pin level
    output logic [NUM_CMP-1:0] pin_oe, // output pin drive enable
    output logic [NUM_CMP-1:0] tmr_gate, // output toward timer
    output logic [NUM_CMP-1:0] cmp_irq_flag, // sticky flags
    output cmpdc_ana_t [NUM_CMP-1:0] ana_ctrl // analog steering
);
    cmpdc_state_t s_r;
    cmpdc_state_t s_nxt;

    function automatic logic [4:0] plus_decode(input logic [2:0] c);
        case (c)
            PSEL_PIN0: plus_decode = 5'h01;
            PSEL_PIN1: plus_decode = 5'h02;
            PSEL_DAC: plus_decode = 5'h04;
            PSEL_FVR: plus_decode = 5'h08;
            SEL_GND: plus_decode = 5'h10;
            default: plus_decode = 5'h00;
        endcase
    endfunction

    function automatic logic [5:0] minus_decode(input logic [2:0] c);
        if (c <= NSEL_PIN4) begin
            minus_decode = 6'(6'h01 << c);
        end else if (c == SEL_GND) begin
            minus_decode = 6'h20;
        end else begin
            minus_decode = 6'h00;
        end
    endfunction

    function automatic logic is_ctrl(input logic [3:0] a, input logic [3:0] b,
                                     input int unsigned n);
        is_ctrl = (a == 4'(b + 4'(2 * n)));
    endfunction

    logic tclk_fall;
    assign tclk_fall = s_r.tclk_prev && !tmr_clk;

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_ana
            logic [2:0] ns;
            assign ns = s_r.ctrl_b[g][B_NSEL_LO +: 3];
            always_comb begin
                ana_ctrl[g].enable = s_r.ctrl_a[g][A_ON];
                ana_ctrl[g].plus_sel = s_r.ctrl_a[g][A_ON] ?
                    plus_decode(s_r.ctrl_b[g][B_PSEL_LO +: 3]) : 5'h00;
                ana_ctrl[g].minus_sel = s_r.ctrl_a[g][A_ON] ?
                    minus_decode(ns) : 6'h00;
                ana_ctrl[g].minus_opamp = s_r.ctrl_a[g][A_ON] &&
                    (ns <= NSEL_PIN4) && minus_opamp_en[g][ns];
                ana_ctrl[g].high_speed = s_r.ctrl_a[g][A_SP];
                ana_ctrl[g].hysteresis = s_r.ctrl_a[g][A_HYS];
            end
        end
    endgenerate

    always_comb begin
        logic v;
        logic cmp;
        v = 1'b0;
        cmp = 1'b0;
        s_nxt = s_r;
        s_nxt.tclk_prev = tmr_clk;
        s_nxt.raw_q = ana_gt;
        s_nxt.raw_s = s_r.raw_q;
        for (int i = 0; i < NUM_CMP; i++) begin
            // disabled comparator reads low before polarity
            cmp = s_r.ctrl_a[i][A_ON] && s_r.raw_s[i];
            v = cmp ^ s_r.ctrl_a[i][A_POL];
            if (s_r.hold[i] != 2'h0) begin
                s_nxt.hold[i] = 2'(s_r.hold[i] - 2'h1);
            end
            if (v != s_r.result[i]) begin
                if (!s_r.ctrl_a[i][A_ZLF] || s_r.hold[i] == 2'h0) begin
                    s_nxt.result[i] = v;
                    s_nxt.hold[i] = ZLF_HOLD_CYC;
                end
            end
            s_nxt.prev[i] = s_r.result[i];
            if (!s_r.ctrl_a[i][A_SYNC] || tclk_fall) begin
                s_nxt.ext[i] = s_nxt.result[i];
            end
            if (wr_en && addr == OFF_IRQ_FLAGS && wdata[i] == 1'b0) begin
                s_nxt.irq[i] = 1'b0;
            end
            // set wins over a clear in the same cycle
            if ((s_r.ctrl_b[i][B_RISE] && s_r.result[i] && !s_r.prev[i]) ||
                (s_r.ctrl_b[i][B_FALL] && !s_r.result[i] && s_r.prev[i])) begin
                s_nxt.irq[i] = 1'b1;
            end
            if (wr_en && is_ctrl(addr, OFF_CTRL_A_BASE, i)) begin
                // result bit is read-only
                s_nxt.ctrl_a[i] = wdata & ~(8'h01 << A_OUT);
            end
            if (wr_en && is_ctrl(addr, OFF_CTRL_B_BASE, i)) begin
                s_nxt.ctrl_b[i] = wdata;
            end
        end
        s_nxt.rdata = 8'h00;
        if (rd_en) begin
            if (addr == OFF_MIRROR) begin
                s_nxt.rdata = {4'h0, s_r.result};
            end else if (addr == OFF_IRQ_FLAGS) begin
                s_nxt.rdata = {4'h0, s_r.irq};
            end
            for (int i = 0; i < NUM_CMP; i++) begin
                if (is_ctrl(addr, OFF_CTRL_A_BASE, i)) begin
                    s_nxt.rdata = s_r.ctrl_a[i] |
                        (8'(s_r.result[i]) << A_OUT);
                end
                if (is_ctrl(addr, OFF_CTRL_B_BASE, i)) begin
                    s_nxt.rdata = s_r.ctrl_b[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
            for (int i = 0; i < NUM_CMP; i++) begin
                s_r.ctrl_a[i] <= CTRL_A_RST;
                s_r.ctrl_b[i] <= CTRL_B_RST;
            end
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_pin
            // drive independent of comparator_on
            assign pin_oe[g] = s_r.ctrl_a[g][A_OE] && !pin_dir_in[g];
            assign pin_out[g] = s_r.ctrl_a[g][A_OE] && s_r.ext[g];
            assign pin_port_rd[g] = !pin_analog[g] && pin_port_in[g];
        end
    endgenerate

    assign tmr_gate = s_r.ext;
    assign cmp_irq_flag = s_r.irq;
    assign rdata = s_r.rdata;
endmodule
`default_nettype wire

// ==== testbench/cmpdc_chk.sv ====
// cmpdc_chk: port assertions for the comparator control block
// assumes: bound into cmpdc_top, one clock domain, sync reset
`timescale 1ns/10ps
`default_nettype none
module cmpdc_chk
    import cmpdc_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic [3:0] addr, // register address
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic [7:0] rdata, // read data
    input wire logic [NUM_CMP-1:0][4:0] minus_opamp_en, // opamp on pin
    input wire logic [NUM_CMP-1:0] pin_dir_in, // direction bits
    input wire logic [NUM_CMP-1:0] pin_analog, // analog select
    input wire logic [NUM_CMP-1:0] pin_port_in, // pin levels
    input wire logic [NUM_CMP-1:0] pin_port_rd, // port read
    input wire logic [NUM_CMP-1:0] pin_oe, // pin drive enable
    input wire logic [NUM_CMP-1:0] cmp_irq_flag, // sticky flags
    input wire cmpdc_ana_t [NUM_CMP-1:0] ana_ctrl // analog steering
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    mirror_high_a: assert property (
        rd_en && addr == OFF_MIRROR |=> rdata[7:4] == 4'h0)
        else $error("mirror upper bits not zero");
    flag_sticky_a: assert property (
        !(wr_en && addr == OFF_IRQ_FLAGS) |=>
        (cmp_irq_flag & $past(cmp_irq_flag)) == $past(cmp_irq_flag))
        else $error("flag dropped without clear");
    pin_dir_a: assert property (
        (pin_oe & pin_dir_in) == 4'h0)
        else $error("pin driven while direction is input");
    port_mask_a: assert property (
        pin_port_rd == (pin_port_in & ~pin_analog))
        else $error("analog pin not read as zero");
    off_nosel_a: assert property (
        !ana_ctrl[0].enable |->
        ana_ctrl[0].plus_sel == 5'h00 && ana_ctrl[0].minus_sel == 6'h00)
        else $error("inputs connected while off");
    plus_onehot_a: assert property (
        $onehot0(ana_ctrl[0].plus_sel))
        else $error("plus selector not one-hot");
    minus_onehot_a: assert property (
        $onehot0(ana_ctrl[0].minus_sel))
        else $error("minus selector not one-hot");
    opamp_feed_a: assert property (
        ana_ctrl[0].enable &&
        (ana_ctrl[0].minus_sel[4:0] & minus_opamp_en[0]) != 5'h00 |->
        ana_ctrl[0].minus_opamp)
        else $error("opamp output not fed to minus input");
endmodule
bind cmpdc_top cmpdc_chk cmpdc_chk_inst (.mclk(mclk), .rst(rst),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .minus_opamp_en(minus_opamp_en), .pin_dir_in(pin_dir_in),
    .pin_analog(pin_analog), .pin_port_in(pin_port_in),
    .pin_port_rd(pin_port_rd), .pin_oe(pin_oe),
    .cmp_irq_flag(cmp_irq_flag), .ana_ctrl(ana_ctrl));
`default_nettype wire

// ==== testbench/cmpdc_top_tb.sv ====
// cmpdc_top_tb: directed bench for the comparator control block
// assumes: register port with read data in the cycle after rd_en
`timescale 1ns/10ps
`default_nettype none
module cmpdc_top_tb;
    import cmpdc_pkg::*;
    logic mclk, rst, ce, wr_en, rd_en, tmr_clk;
    logic [3:0] addr, ana_gt, pin_dir_in, pin_analog, pin_port_in;
    logic [7:0] wdata, rdata;
    logic [NUM_CMP-1:0][4:0] minus_opamp_en;
    logic [3:0] pin_port_rd, pin_out, pin_oe, tmr_gate, cmp_irq_flag;
    cmpdc_ana_t [NUM_CMP-1:0] ana_ctrl;
    int errors = 0;
    int samples_checked = 0;
    logic [7:0] pexp [8] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h04,
        8'h08, 8'h10};
    logic [7:0] nexp [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00,
        8'h00, 8'h20};
    cmpdc_top cmpdc_top_inst (.mclk(mclk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .ana_gt(ana_gt), .minus_opamp_en(minus_opamp_en),
        .tmr_clk(tmr_clk), .pin_dir_in(pin_dir_in),
        .pin_analog(pin_analog), .pin_port_in(pin_port_in),
        .pin_port_rd(pin_port_rd), .pin_out(pin_out), .pin_oe(pin_oe),
        .tmr_gate(tmr_gate), .cmp_irq_flag(cmp_irq_flag),
        .ana_ctrl(ana_ctrl));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check8(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        check8("rdata", exp, rdata);
    endtask
    task automatic t_reset_vals;
        rd(4'h0, 8'h04);
        rd(4'h1, 8'h00);
        rd(OFF_MIRROR, 8'h00);
        rd(4'hF, 8'h00);
    endtask
    task automatic t_select;
        wr(4'h0, 8'h80);
        for (int i = 0; i < 8; i++) begin
            wr(4'h1, 8'(i * 8));
            #1;
            check8("plus_sel", pexp[i], {3'h0, ana_ctrl[0].plus_sel});
            wr(4'h1, 8'(i));
            #1;
            check8("minus_sel", nexp[i], {2'h0, ana_ctrl[0].minus_sel});
        end
    endtask
    task automatic edge_case(input logic [7:0] ca, input logic [7:0] fl);
        wr(4'h0, ca);
        repeat (6) @(posedge mclk);
        rd(OFF_IRQ_FLAGS, fl);
        wr(OFF_IRQ_FLAGS, 8'h00);
    endtask
    task automatic t_irq;
        wr(4'h0, 8'h84);
        wr(4'h1, 8'h80);
        wr(OFF_IRQ_FLAGS, 8'h00);
        ana_gt <= 4'h1;
        repeat (6) @(posedge mclk);
        rd(OFF_MIRROR, 8'h01);
        rd(OFF_IRQ_FLAGS, 8'h01);
        rd(OFF_IRQ_FLAGS, 8'h01);
        wr(OFF_IRQ_FLAGS, 8'h00);
        edge_case(8'h94, 8'h00);
        rd(OFF_MIRROR, 8'h00);
        wr(4'h1, 8'h40);
        edge_case(8'h84, 8'h00);
        edge_case(8'h94, 8'h01);
        wr(4'h1, 8'hC0);
        // off with inverted polarity gives a rising edge
        edge_case(8'h14, 8'h01);
    endtask
    task automatic t_pin;
        wr(4'h0, 8'hA4);
        repeat (6) @(posedge mclk);
        #1;
        check8("pin", 8'h03, {6'h00, pin_oe[0], pin_out[0]});
        check8("port_rd", 8'h08, {4'h0, pin_port_rd});
        check8("speed_hys", 8'h02,
            {6'h00, ana_ctrl[0].high_speed, ana_ctrl[0].hysteresis});
    endtask
    task automatic t_sync;
        wr(4'h0, 8'h87);
        ana_gt <= 4'h0;
        repeat (6) @(posedge mclk);
        #1;
        check8("tmr_gate_held", 8'h01, {7'h00, tmr_gate[0]});
        check8("hysteresis", 8'h01, {7'h00, ana_ctrl[0].hysteresis});
        @(posedge mclk);
        tmr_clk <= 1'b1;
        @(posedge mclk);
        tmr_clk <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check8("tmr_gate_fall", 8'h00, {7'h00, tmr_gate[0]});
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        {wr_en, rd_en, tmr_clk} = 3'h0;
        addr = 4'h0;
        wdata = 8'h00;
        ana_gt = 4'h0;
        minus_opamp_en = '{5'h00, 5'h00, 5'h00, 5'h01};
        pin_dir_in = 4'hE;
        pin_analog = 4'h3;
        pin_port_in = 4'hA;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset_vals();
        t_select();
        t_irq();
        t_pin();
        t_sync();
        final_report();
    end
endmodule
`default_nettype wire
